/* File: inc/ftrb_map.vh */
// Register indices, reset value and sizes of the telemetry readback bank
`ifndef FTRB_MAP_VH
`define FTRB_MAP_VH

// Word indices; the byte address on the register port is four times the index
`define FTRB_IDX_PHASE_C_VOLTAGE 16'h047E
`define FTRB_IDX_COMMUTATION_SINE 16'h04B6
`define FTRB_IDX_COMMUTATION_COSINE 16'h04B8
`define FTRB_IDX_STATIONARY_CURRENT_A_AXIS 16'h04D2
`define FTRB_IDX_STATIONARY_CURRENT_B_AXIS 16'h04D4
`define FTRB_IDX_STATIONARY_VOLTAGE_A_AXIS 16'h04D6
`define FTRB_IDX_STATIONARY_VOLTAGE_B_AXIS 16'h04D8
`define FTRB_IDX_DIRECT_AXIS_CURRENT 16'h04E2
`define FTRB_IDX_QUADRATURE_AXIS_CURRENT 16'h04E4
`define FTRB_IDX_DIRECT_AXIS_VOLTAGE 16'h04E6
`define FTRB_IDX_QUADRATURE_AXIS_VOLTAGE 16'h04E8
`define FTRB_IDX_ALIGN_CURRENT_REFERENCE 16'h0524
`define FTRB_IDX_HANDOVER_SPEED_REFERENCE 16'h053C

// Byte address width and word layout
`define FTRB_ADDR_W 16
`define FTRB_DATA_W 32
`define FTRB_NUM_WORDS 13
`define FTRB_FRAC_BITS 27
`define FTRB_WORD_RESET 32'h00000000
`define FTRB_UNMAPPED_READ 32'h00000000

`endif

/* File: src/ftrb_bank.v */
// Read-only telemetry register bank for the field-oriented control loop
`include "ftrb_map.vh"

// Function
// - Present the phase C voltage caught during initial speed detection as a 32-bit word scaled 60/sqrt3 by 2^27.
// - Present the sine of the commutation angle as a signed word with 27 fractional bits.
// - Present the cosine of the commutation angle as a signed word with 27 fractional bits.
// - Present the alpha-axis current as a word that over 2^27 times base current over 8 gives amperes.
// - Present the beta-axis current with the same scaling as the alpha-axis current.
// - Present the alpha-axis voltage as a word that over 2^27 times 60 over sqrt3 gives volts.
// - Present the beta-axis voltage with the same scaling as the alpha-axis voltage.
// - Present the estimated direct-axis current scaled by 2^27 and base current over 8.
// - Present the estimated quadrature-axis current scaled by 2^27 and base current over 8.
// - Present the applied direct-axis voltage scaled by 2^27 and 60 over sqrt3.
// - Present the applied quadrature-axis voltage scaled by 2^27 and 60 over sqrt3.
// - Present the rotor-align quadrature current reference scaled by 2^27 and base current over 8.
// - Present the open-loop speed at which control hands over to closed loop as a read-only word.
// - Every word clears to zero on reset and ignores software writes.
// - The open-loop speed word over 2^27 times the maximum speed gives hertz.
module ftrb_bank
(
  input wire sys_clk, // 40 MHz clock
  input wire arst_n, // Asynchronous reset, active low
  input wire [`FTRB_ADDR_W-1:0] reg_addr, // Byte address
  input wire [`FTRB_DATA_W-1:0] reg_wdata, // Write data, ignored
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [`FTRB_DATA_W-1:0] reg_rdata, // Read data, cycle after the strobe
  output reg reg_rvalid, // Marks the read data cycle
  output reg reg_wr_ignored, // Pulse: a write arrived and was dropped
  input wire ctl_update, // Control loop has fresh values this cycle
  input wire [31:0] ctl_phase_c_voltage, // Phase C voltage, 2^27 scaled
  input wire [31:0] ctl_commutation_sine, // Sine of angle, Q4.27
  input wire [31:0] ctl_commutation_cosine, // Cosine of angle, Q4.27
  input wire [31:0] ctl_stationary_current_a_axis, // Alpha current
  input wire [31:0] ctl_stationary_current_b_axis, // Beta current
  input wire [31:0] ctl_stationary_voltage_a_axis, // Alpha voltage
  input wire [31:0] ctl_stationary_voltage_b_axis, // Beta voltage
  input wire [31:0] ctl_direct_axis_current, // Estimated d current
  input wire [31:0] ctl_quadrature_axis_current, // Estimated q current
  input wire [31:0] ctl_direct_axis_voltage, // Applied d voltage
  input wire [31:0] ctl_quadrature_axis_voltage, // Applied q voltage
  input wire [31:0] ctl_align_current_reference, // Align q current reference
  input wire [31:0] ctl_handover_speed_reference // Open-loop handover speed
);

  wire [`FTRB_DATA_W-1:0] src_w [0:`FTRB_NUM_WORDS-1];
  wire [`FTRB_ADDR_W-1:0] idx_w [0:`FTRB_NUM_WORDS-1];
  wire [`FTRB_DATA_W-1:0] word_w [0:`FTRB_NUM_WORDS-1];
  reg [`FTRB_DATA_W-1:0] rdata_d;
  wire [`FTRB_ADDR_W-1:0] index_w;
  wire aligned_w;
  integer k;

  assign src_w[0] = ctl_phase_c_voltage;
  assign src_w[1] = ctl_commutation_sine;
  assign src_w[2] = ctl_commutation_cosine;
  assign src_w[3] = ctl_stationary_current_a_axis;
  assign src_w[4] = ctl_stationary_current_b_axis;
  assign src_w[5] = ctl_stationary_voltage_a_axis;
  assign src_w[6] = ctl_stationary_voltage_b_axis;
  assign src_w[7] = ctl_direct_axis_current;
  assign src_w[8] = ctl_quadrature_axis_current;
  assign src_w[9] = ctl_direct_axis_voltage;
  assign src_w[10] = ctl_quadrature_axis_voltage;
  assign src_w[11] = ctl_align_current_reference;
  assign src_w[12] = ctl_handover_speed_reference;

  assign idx_w[0] = `FTRB_IDX_PHASE_C_VOLTAGE;
  assign idx_w[1] = `FTRB_IDX_COMMUTATION_SINE;
  assign idx_w[2] = `FTRB_IDX_COMMUTATION_COSINE;
  assign idx_w[3] = `FTRB_IDX_STATIONARY_CURRENT_A_AXIS;
  assign idx_w[4] = `FTRB_IDX_STATIONARY_CURRENT_B_AXIS;
  assign idx_w[5] = `FTRB_IDX_STATIONARY_VOLTAGE_A_AXIS;
  assign idx_w[6] = `FTRB_IDX_STATIONARY_VOLTAGE_B_AXIS;
  assign idx_w[7] = `FTRB_IDX_DIRECT_AXIS_CURRENT;
  assign idx_w[8] = `FTRB_IDX_QUADRATURE_AXIS_CURRENT;
  assign idx_w[9] = `FTRB_IDX_DIRECT_AXIS_VOLTAGE;
  assign idx_w[10] = `FTRB_IDX_QUADRATURE_AXIS_VOLTAGE;
  assign idx_w[11] = `FTRB_IDX_ALIGN_CURRENT_REFERENCE;
  assign idx_w[12] = `FTRB_IDX_HANDOVER_SPEED_REFERENCE;

  // Only whole aligned words decode; the top two index bits fall off the 16-bit address
  assign aligned_w = (reg_addr[1:0] == 2'h0);
  assign index_w = {2'h0, reg_addr[`FTRB_ADDR_W-1:2]};

  // All words load on the same edge, so a read never mixes two loop updates
  genvar g;
  generate
    for (g = 0; g < `FTRB_NUM_WORDS; g = g + 1)
    begin : g_word
      // Each word lives in its own block so that no array has several drivers
      reg [`FTRB_DATA_W-1:0] word_q;
      always @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
          word_q <= `FTRB_WORD_RESET;
        else if (ctl_update)
          word_q <= src_w[g];
      end
      assign word_w[g] = word_q;
    end
  endgenerate

  always @*
  begin
    rdata_d = `FTRB_UNMAPPED_READ;
    for (k = 0; k < `FTRB_NUM_WORDS; k = k + 1)
    begin
      if (aligned_w && (index_w == idx_w[k]))
        rdata_d = word_w[k];
    end
  end

  // Read data is held only in the cycle after the strobe; zero otherwise
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= `FTRB_WORD_RESET;
      reg_rvalid <= 1'b0;
      reg_wr_ignored <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_d : `FTRB_WORD_RESET;
      reg_rvalid <= reg_rd;
      reg_wr_ignored <= reg_wr;
    end
  end

endmodule

/* File: sim/ftrb_checker.sv */
// Port-level assertions for the telemetry readback bank
module ftrb_checker (
  input wire sys_clk, // Clock
  input wire arst_n, // Reset, active low
  input wire [15:0] reg_addr, // Byte address
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [31:0] reg_rdata, // Read data
  input wire reg_rvalid, // Read data marker
  input wire reg_wr_ignored, // Dropped write pulse
  input wire ctl_update, // Snapshot strobe
  input wire [31:0] ctl_phase_c_voltage, // Phase C source
  input wire [31:0] ctl_commutation_sine // Sine source
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_snap_rd(a);
    ctl_update ##1 (reg_rd && reg_addr == a);
  endsequence
  sequence s_twice_rd;
    (reg_rd && reg_addr == 16'h11F8 && !ctl_update) ##1 !ctl_update ##1 (reg_rd && reg_addr == 16'h11F8);
  endsequence
  chk_rd_answered: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  chk_rd_quiet: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 32'h0) else $error("stray read data");
  chk_wr_dropped: assert property (reg_wr |=> reg_wr_ignored) else $error("write not flagged");
  chk_wr_quiet: assert property (!reg_wr |=> !reg_wr_ignored) else $error("stray write flag");
  chk_phase_c_snap: assert property (s_snap_rd(16'h11F8) |=> reg_rdata == $past(ctl_phase_c_voltage, 2))
    else $error("phase C word not from snapshot");
  chk_sine_snap: assert property (s_snap_rd(16'h12D8) |=> reg_rdata == $past(ctl_commutation_sine, 2))
    else $error("sine word not from snapshot");
  chk_unaligned_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
    else $error("unaligned read not zero");
  chk_word_holds: assert property (s_twice_rd |=> reg_rdata == $past(reg_rdata, 2))
    else $error("word changed without update");
endmodule
bind ftrb_bank ftrb_checker i_chk (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr_ignored(reg_wr_ignored),
  .ctl_update(ctl_update), .ctl_phase_c_voltage(ctl_phase_c_voltage), .ctl_commutation_sine(ctl_commutation_sine));

/* File: sim/ftrb_bank_tb.sv */
// Self-checking bench for the telemetry readback bank
module ftrb_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, ctl_update = 0, reg_rvalid, reg_wr_ignored;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, w [13], old [13];
  logic [15:0] ad [13] = '{16'h11F8, 16'h12D8, 16'h12E0, 16'h1348, 16'h1350, 16'h1358, 16'h1360,
    16'h1388, 16'h1390, 16'h1398, 16'h13A0, 16'h1490, 16'h14F0};
  int fails = 0, n_compared = 0, cyc = 0;
  ftrb_bank i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr_ignored(reg_wr_ignored),
    .ctl_update(ctl_update), .ctl_phase_c_voltage(w[0]), .ctl_commutation_sine(w[1]), .ctl_commutation_cosine(w[2]),
    .ctl_stationary_current_a_axis(w[3]), .ctl_stationary_current_b_axis(w[4]), .ctl_stationary_voltage_a_axis(w[5]),
    .ctl_stationary_voltage_b_axis(w[6]), .ctl_direct_axis_current(w[7]), .ctl_quadrature_axis_current(w[8]),
    .ctl_direct_axis_voltage(w[9]), .ctl_quadrature_axis_voltage(w[10]), .ctl_align_current_reference(w[11]),
    .ctl_handover_speed_reference(w[12]));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected read answer: the last snapshot for a mapped word, zero for anything else
  function automatic logic [31:0] exp_word(input logic [15:0] a);
    exp_word = 32'h0;
    foreach (ad[k])
      if (a == ad[k])
        exp_word = old[k];
  endfunction
  // Called right after a rising edge; returns right after the edge that follows the data cycle
  task automatic rd(input logic [15:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp_word(a));
    chk({31'h0, reg_rvalid}, 32'h1);
    @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
    forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fails++;
      close_out();
    end
  end
  initial
  begin
    foreach (w[k]) w[k] = 32'h0;
    old = w;
    void'($urandom(32'hEC0C42DC));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (ad[k]) rd(ad[k]);
    $display("reset values test done");
    for (int i = 0; i < 26; i++)
    begin
      ctl_update <= 1'b1;
      foreach (w[k]) w[k] <= $urandom;
      @(posedge sys_clk);
      ctl_update <= 1'b0;
      old = w;
      // First read lands in the cycle right after the snapshot edge
      foreach (ad[k]) rd(ad[(k + i) % 13]);
      reg_wr <= 1'b1;
      reg_wdata <= $urandom;
      reg_addr <= ad[i % 13];
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1 chk({31'h0, reg_wr_ignored}, 32'h1);
      @(posedge sys_clk);
      rd(ad[i % 13]);
    end
    $display("snapshot and write test done");
    foreach (w[k]) w[k] <= ~w[k];
    rd(ad[0]);
    rd(ad[0]);
    rd(ad[0] + 16'h1);
    rd(16'h11FC);
    $display("hold and unmapped test done");
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (old[k]) old[k] = 32'h0;
    foreach (ad[k]) rd(ad[k]);
    $display("mid-run reset test done");
    close_out();
  end
endmodule
